// ### cmro_consts.svh
// Constants of the move and return instruction unit: encodings, offsets, reset values
`ifndef CMRO_CONSTS_SVH
`define CMRO_CONSTS_SVH

// ==========================================================
// Instruction encodings (14-bit instruction word)
`define CMRO_OP_NOP 14'h0000
`define CMRO_OP_RESET 14'h0001
`define CMRO_OP_RETURN 14'h0008
`define CMRO_OP_RETFI 14'h0009
`define CMRO_OP_OPTION 14'h0062
`define CMRO_OP_DIRECT_HI 7'h01
`define CMRO_OP_IND_MODE_HI 11'h003
`define CMRO_OP_IND_REL_HI 7'h7F

// ==========================================================
// Instruction field positions
`define CMRO_F_DIRECT_ADDR_MSB 6
`define CMRO_F_IND_MODE_SEL 2
`define CMRO_F_IND_REL_SEL 6
`define CMRO_F_IND_REL_OFF_MSB 5

// ==========================================================
// Indirect window locations in the file register space
`define CMRO_WINDOW0 7'h00
`define CMRO_WINDOW1 7'h01

// ==========================================================
// Register port offsets
`define CMRO_REG_ACC 4'h0
`define CMRO_REG_OPTION 4'h1
`define CMRO_REG_PTR0_LO 4'h2
`define CMRO_REG_PTR0_HI 4'h3
`define CMRO_REG_PTR1_LO 4'h4
`define CMRO_REG_PTR1_HI 4'h5
`define CMRO_REG_INTCTL 4'h6
`define CMRO_REG_PWRCTL 4'h7
`define CMRO_REG_STATUS 4'h8
`define CMRO_REG_PC_LO 4'h9
`define CMRO_REG_PC_HI 4'hA

// ==========================================================
// Field positions and reset values
`define CMRO_GLB_INT_EN_BIT 7
`define CMRO_RI_FLAG_BIT 2
`define CMRO_RST_ACC 8'h00
`define CMRO_RST_OPTION 8'hFF
`define CMRO_RST_PTR 16'h0000
`define CMRO_RST_INTCTL 8'h00
`define CMRO_RST_PWRCTL 8'h04
`define CMRO_RST_STATUS 8'h00
`define CMRO_RST_PC 15'h0000

`endif

// ### cmro_pkg.sv
// Types of the move and return instruction unit
`default_nettype none

package cmro_pkg;

  // ==========================================================
  // Execution phase
  typedef enum logic [0:0]
  {
    CMRO_PH_RUN,
    CMRO_PH_FLUSH
  } cmro_phase_t;

  // ==========================================================
  // Whole state of the core
  typedef struct packed
  {
    cmro_phase_t phase;
    logic [7:0] acc;
    logic [7:0] option;
    logic [1:0][15:0] ptr;
    logic [7:0] intctl;
    logic [7:0] pwrctl;
    logic [7:0] status;
    logic [14:0] pc;
    logic [7:0] rd_data;
    logic mem_wr;
    logic [15:0] mem_addr;
    logic [7:0] mem_data;
    logic stack_pop;
    logic soft_rst;
    logic unhandled;
  } cmro_state_t;

endpackage : cmro_pkg

`default_nettype wire

// ### cmro_ptr_if.sv
// Carrier between the core and its pointer arithmetic unit
`default_nettype none

interface cmro_ptr_if;
  logic [15:0] ptr;
  logic [1:0] mode;
  logic rel;
  logic [5:0] offset;
  logic [15:0] eff_addr;
  logic [15:0] ptr_next;

  modport core
  (
    output ptr,
    output mode,
    output rel,
    output offset,
    input eff_addr,
    input ptr_next
  );

  modport unit
  (
    input ptr,
    input mode,
    input rel,
    input offset,
    output eff_addr,
    output ptr_next
  );
endinterface : cmro_ptr_if

`default_nettype wire

// ### cmro_ptr_unit.sv
// Effective address and pointer update for the indirect store
`default_nettype none

module cmro_ptr_unit
(
  // Pointer request and result
  cmro_ptr_if.unit pif
);

  // ==========================================================
  // Address arithmetic
  logic [15:0] ptr_inc;
  logic [15:0] ptr_dec;
  logic [15:0] off_ext;

  // 16-bit adders drop the carry, so the pointer wraps at both ends
  assign ptr_inc = pif.ptr + 16'h0001; // see [RL6]
  assign ptr_dec = pif.ptr - 16'h0001; // see [RL6]
  assign off_ext = {{10{pif.offset[5]}}, pif.offset};

  // Mode bit 1 low means pre-update, bit 0 low means increment
  always_comb
  begin
    if (pif.rel)
    begin
      pif.eff_addr = pif.ptr + off_ext; // see [RL3]
      pif.ptr_next = pif.ptr; // see [RL4]
    end
    else
    begin
      pif.ptr_next = pif.mode[0] ? ptr_dec : ptr_inc; // see [RL4]
      pif.eff_addr = pif.mode[1] ? pif.ptr : pif.ptr_next; // see [RL2] see [RL3]
    end
  end

endmodule : cmro_ptr_unit

`default_nettype wire

// ### cmro_core.sv
// Move, indirect store, option load, software reset and return instructions
//
// Overview of operation
// [RL1] Direct store copies accumulator, one cycle
// [RL2] Indirect store picks pointer, decodes mode field
// [RL3] Effective address: pointer, plus one, minus one, or plus offset
// [RL4] Pointer updated by one, or kept for offset
// [RL5] Window location redirects to pointer's address
// [RL6] Pointers are sixteen bits and wrap
// [RL7] Indirect store never touches status flags
// [RL8] Option load copies accumulator, flags untouched
// [RL9] Software reset resets device, clears reset flag
// [RL10] Interrupt return pops stack, sets global enable
// [RL11] Subroutine return pops stack, two cycles
// [RL12] No-operation only advances the program counter
`default_nettype none

`include "cmro_consts.svh"

module cmro_core
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,

  // Instruction stream
  input wire logic instr_valid,
  input wire logic [13:0] instr_word,
  output logic instr_ready,
  output logic instr_unhandled,

  // Hardware stack
  input wire logic [14:0] stack_top,
  output logic stack_pop,

  // Data memory write port
  output logic mem_wr,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_data,

  // Core state seen by the rest of the device
  output logic [14:0] pc,
  output logic [7:0] timer_option,
  output logic global_interrupt_enable,
  output logic soft_reset_pulse,

  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata
);

  // ==========================================================
  // State
  cmro_pkg::cmro_state_t st_reg;
  cmro_pkg::cmro_state_t st_next;

  // The whole core lives in one packed image: one always_comb builds the
  // next image from the current one and one always_ff registers it. Pulses
  // (memory write, stack pop, software reset, unhandled) are cleared at the
  // top of the next-state process, so each stands for exactly one cycle.

  // Reset image, shared by the reset pin and the reset instruction
  function automatic cmro_pkg::cmro_state_t cmro_reset_state(input logic ri_flag);
    cmro_pkg::cmro_state_t s;
    s = '0;
    s.phase = cmro_pkg::CMRO_PH_RUN;
    s.acc = `CMRO_RST_ACC;
    s.option = `CMRO_RST_OPTION;
    s.ptr[0] = `CMRO_RST_PTR;
    s.ptr[1] = `CMRO_RST_PTR;
    s.intctl = `CMRO_RST_INTCTL;
    s.pwrctl = `CMRO_RST_PWRCTL;
    s.pwrctl[`CMRO_RI_FLAG_BIT] = ri_flag;
    s.status = `CMRO_RST_STATUS;
    s.pc = `CMRO_RST_PC;
    return s;
  endfunction : cmro_reset_state

  // Register read multiplexer; unmapped offsets read as zero
  // Reads see the image before any same-cycle write: a read and a write to
  // one offset in one cycle return the old value.
  function automatic logic [7:0] cmro_read_mux(input cmro_pkg::cmro_state_t s,
                                                input logic [3:0] a);
    logic [7:0] d;
    d = 8'h00;
    unique case (a)
      `CMRO_REG_ACC: d = s.acc;
      `CMRO_REG_OPTION: d = s.option;
      `CMRO_REG_PTR0_LO: d = s.ptr[0][7:0];
      `CMRO_REG_PTR0_HI: d = s.ptr[0][15:8];
      `CMRO_REG_PTR1_LO: d = s.ptr[1][7:0];
      `CMRO_REG_PTR1_HI: d = s.ptr[1][15:8];
      `CMRO_REG_INTCTL: d = s.intctl;
      `CMRO_REG_PWRCTL: d = s.pwrctl;
      `CMRO_REG_STATUS: d = s.status;
      `CMRO_REG_PC_LO: d = s.pc[7:0];
      `CMRO_REG_PC_HI: d = {1'b0, s.pc[14:8]};
      default: d = 8'h00;
    endcase
    return d;
  endfunction : cmro_read_mux

  // ==========================================================
  // Decode
  // Decode is flat: every form is matched on its fixed opcode bits alone, and
  // the first match in the execution chain below wins. The two window
  // addresses of the direct store are peeled off first, since a plain store
  // there would land on a location that has no storage behind it.
  // Words outside the subset raise the unhandled pulse and change nothing,
  // not even the program counter, so the rest of the core can execute them.
  logic take;
  logic is_nop;
  logic is_reset;
  logic is_return;
  logic is_retfi;
  logic is_option;
  logic is_direct;
  logic is_ind_mode;
  logic is_ind_rel;
  logic is_window;
  logic ptr_sel;
  logic [6:0] direct_addr;

  // A two-cycle return holds off the next instruction during its flush cycle
  assign instr_ready = (st_reg.phase == cmro_pkg::CMRO_PH_RUN); // see [RL10] see [RL11]
  assign take = instr_valid && instr_ready;

  assign direct_addr = instr_word[`CMRO_F_DIRECT_ADDR_MSB:0];
  assign is_nop = (instr_word == `CMRO_OP_NOP);
  assign is_reset = (instr_word == `CMRO_OP_RESET);
  assign is_return = (instr_word == `CMRO_OP_RETURN);
  assign is_retfi = (instr_word == `CMRO_OP_RETFI);
  assign is_option = (instr_word == `CMRO_OP_OPTION);
  assign is_direct = (instr_word[13:7] == `CMRO_OP_DIRECT_HI);
  assign is_ind_mode = (instr_word[13:3] == `CMRO_OP_IND_MODE_HI);
  assign is_ind_rel = (instr_word[13:7] == `CMRO_OP_IND_REL_HI);
  assign is_window = is_direct
                     && ((direct_addr == `CMRO_WINDOW0) || (direct_addr == `CMRO_WINDOW1));

  // Pointer choice: mode form, offset form, or the window that was named
  always_comb
  begin
    if (is_ind_mode)
      ptr_sel = instr_word[`CMRO_F_IND_MODE_SEL]; // see [RL2]
    else if (is_ind_rel)
      ptr_sel = instr_word[`CMRO_F_IND_REL_SEL]; // see [RL2]
    else
      ptr_sel = (direct_addr == `CMRO_WINDOW1); // see [RL5]
  end

  // ==========================================================
  // Pointer arithmetic
  // One shared pointer unit serves every pointer form. The mode form uses the
  // mode bits; the offset form and the window both take the offset path, the
  // window with a zero offset, so neither of them moves the pointer.
  cmro_ptr_if pif ();

  // A window access rides the offset form with a zero offset: address is the pointer itself
  assign pif.ptr = st_reg.ptr[ptr_sel];
  assign pif.mode = instr_word[1:0]; // see [RL2]
  assign pif.rel = !is_ind_mode; // see [RL5]
  assign pif.offset = is_ind_rel ? instr_word[`CMRO_F_IND_REL_OFF_MSB:0] : 6'h00; // see [RL3]

  // The unit is purely combinational; its results are used only in the
  // cycle in which an indirect or window store is taken, and are ignored
  // otherwise.
  cmro_ptr_unit u_ptr
  (
    .pif(pif)
  );

  // ==========================================================
  // Next state
  // Priority, lowest first: hold, software register write, instruction,
  // software reset. A later stage overwrites what an earlier one wrote, so
  // an instruction beats a same-cycle software write to the same register
  // and the reset instruction discards both. Status is kept as it is by
  // every instruction here; only a software write or a reset changes it.
  always_comb
  begin
    st_next = st_reg;
    st_next.mem_wr = 1'b0;
    st_next.stack_pop = 1'b0;
    st_next.soft_rst = 1'b0;
    st_next.unhandled = 1'b0;
    st_next.phase = cmro_pkg::CMRO_PH_RUN;

    // Read data stand for exactly one cycle after the strobe
    st_next.rd_data = reg_rd ? cmro_read_mux(st_reg, reg_addr) : 8'h00;

    // Software writes; an instruction in the same cycle overrides them below
    if (reg_wr)
    begin
      unique case (reg_addr)
        `CMRO_REG_ACC: st_next.acc = reg_wdata;
        `CMRO_REG_OPTION: st_next.option = reg_wdata;
        `CMRO_REG_PTR0_LO: st_next.ptr[0][7:0] = reg_wdata;
        `CMRO_REG_PTR0_HI: st_next.ptr[0][15:8] = reg_wdata;
        `CMRO_REG_PTR1_LO: st_next.ptr[1][7:0] = reg_wdata;
        `CMRO_REG_PTR1_HI: st_next.ptr[1][15:8] = reg_wdata;
        `CMRO_REG_INTCTL: st_next.intctl = reg_wdata;
        `CMRO_REG_PWRCTL: st_next.pwrctl = reg_wdata;
        `CMRO_REG_STATUS: st_next.status = reg_wdata;
        default:
        begin
        end
      endcase
    end

    // Instruction execution; none of them changes status, the indirect store writes back its old value
    if (take)
    begin
      if (is_nop)
      begin
        st_next.pc = st_reg.pc + 15'h0001; // see [RL12]
      end
      else if (is_direct && !is_window)
      begin
        st_next.mem_wr = 1'b1; // see [RL1]
        st_next.mem_addr = {9'h000, direct_addr}; // see [RL1]
        st_next.mem_data = st_reg.acc; // see [RL1]
        st_next.pc = st_reg.pc + 15'h0001; // see [RL1]
      end
      else if (is_window)
      begin
        // No storage behind the window: the write lands where the pointer points
        st_next.mem_wr = 1'b1; // see [RL5]
        st_next.mem_addr = pif.eff_addr; // see [RL5]
        st_next.mem_data = st_reg.acc; // see [RL5]
        st_next.pc = st_reg.pc + 15'h0001;
      end
      else if (is_ind_mode || is_ind_rel)
      begin
        st_next.mem_wr = 1'b1; // see [RL2]
        st_next.mem_addr = pif.eff_addr; // see [RL3]
        st_next.mem_data = st_reg.acc;
        st_next.ptr[ptr_sel] = pif.ptr_next; // see [RL4] see [RL6] see [RL7]
        st_next.status = st_reg.status; // see [RL7]
        st_next.pc = st_reg.pc + 15'h0001;
      end
      else if (is_option)
      begin
        st_next.option = st_reg.acc; // see [RL8]
        st_next.pc = st_reg.pc + 15'h0001; // see [RL8]
      end
      else if (is_return || is_retfi)
      begin
        // First cycle pops the stack, second cycle is the flush
        st_next.stack_pop = 1'b1; // see [RL10] see [RL11]
        st_next.pc = stack_top; // see [RL10] see [RL11]
        st_next.phase = cmro_pkg::CMRO_PH_FLUSH; // see [RL10] see [RL11]
        if (is_retfi)
          st_next.intctl[`CMRO_GLB_INT_EN_BIT] = 1'b1; // see [RL10]
      end
      else if (is_reset)
      begin
        st_next.pc = st_reg.pc;
      end
      else
      begin
        // Instructions outside this unit are left to the rest of the core
        st_next.unhandled = 1'b1;
      end
    end

    // Software reset: whole image back to reset, reset flag cleared to mark the cause
    if (take && is_reset)
    begin
      st_next = cmro_reset_state(1'b0); // see [RL9]
      st_next.soft_rst = 1'b1; // see [RL9]
    end
  end

  // ==========================================================
  // State register
  // Synchronous reset only: the reset image sets the reset-instruction flag,
  // so software reading the power control register can tell the two causes
  // apart after the fact.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      st_reg <= cmro_reset_state(1'b1);
    else
      st_reg <= st_next;
  end

  // ==========================================================
  // Outputs, all from the state register
  // Only instr_ready is combinational: it must drop in the very cycle after
  // a return is taken, to hold off the next instruction.
  assign instr_unhandled = st_reg.unhandled;
  assign stack_pop = st_reg.stack_pop;
  assign mem_wr = st_reg.mem_wr;
  assign mem_addr = st_reg.mem_addr;
  assign mem_data = st_reg.mem_data;
  assign pc = st_reg.pc;
  assign timer_option = st_reg.option;
  assign global_interrupt_enable = st_reg.intctl[`CMRO_GLB_INT_EN_BIT];
  assign soft_reset_pulse = st_reg.soft_rst;
  assign reg_rdata = st_reg.rd_data;

endmodule : cmro_core

`default_nettype wire

// ### cmro_chk.sv
// Port checker of the move and return unit
`default_nettype none

// ==========================================================
// Checker
module cmro_chk
(
  // Watched ports
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic instr_valid,
  input wire logic [13:0] instr_word,
  input wire logic instr_ready,
  input wire logic [14:0] stack_top,
  input wire logic stack_pop,
  input wire logic mem_wr,
  input wire logic [15:0] mem_addr,
  input wire logic [14:0] pc,
  input wire logic global_interrupt_enable,
  input wire logic soft_reset_pulse
);
  logic tk;
  logic ret;
  // Taking edge, and the two return encodings
  assign tk = instr_valid && instr_ready;
  assign ret = tk && instr_word[13:1] == 13'h0004;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  chk_direct_addr: assert property (
    tk && instr_word[13:7] == 7'h01 && instr_word[6:1] != 6'h00
    |=> mem_wr && mem_addr == {9'h000, $past(instr_word[6:0])})
    else $error("direct store address wrong");
  chk_wr_cause: assert property (
    mem_wr |-> $past(tk && (instr_word[13:7] == 7'h01 || instr_word[13:3] == 11'h003
    || instr_word[13:7] == 7'h7F)))
    else $error("memory write without a store");
  chk_return_pop: assert property (
    ret |=> stack_pop && !instr_ready && pc == $past(stack_top))
    else $error("return did not pop into pc");
  chk_pop_cause: assert property (
    stack_pop |-> $past(ret))
    else $error("stack pop without a return");
  chk_ready_back: assert property (
    !instr_ready |=> instr_ready)
    else $error("flush cycle longer than one");
  chk_retfi_int_enable: assert property (
    tk && instr_word == 14'h0009 |=> global_interrupt_enable)
    else $error("interrupt return left enable low");
  chk_nop_pc: assert property (
    tk && instr_word == 14'h0000 |=> !mem_wr && !stack_pop && pc == $past(pc) + 15'h0001)
    else $error("no-operation did more than advance");
  chk_reset_pulse: assert property (
    tk && instr_word == 14'h0001 |=> soft_reset_pulse && pc == 15'h0000)
    else $error("software reset not carried out");
  // Main scenarios reached
  cover property (ret ##1 global_interrupt_enable);
  cover property (mem_wr);
  cover property (soft_reset_pulse);
endmodule : cmro_chk

bind cmro_core cmro_chk u_chk
(
  .clk_sys(clk_sys),
  .srst(srst),
  .instr_valid(instr_valid),
  .instr_word(instr_word),
  .instr_ready(instr_ready),
  .stack_top(stack_top),
  .stack_pop(stack_pop),
  .mem_wr(mem_wr),
  .mem_addr(mem_addr),
  .pc(pc),
  .global_interrupt_enable(global_interrupt_enable),
  .soft_reset_pulse(soft_reset_pulse)
);

`default_nettype wire

// ### testbench.sv
// Self-checking bench of the move and return unit
`default_nettype none

// ==========================================================
// Bench top
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic instr_valid = 1'b0;
  logic [13:0] instr_word = 14'h0000;
  logic [14:0] stack_top = 15'h0000;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic instr_ready, instr_unhandled, stack_pop, mem_wr;
  logic global_interrupt_enable, soft_reset_pulse;
  logic [15:0] mem_addr;
  logic [7:0] mem_data, timer_option, reg_rdata;
  logic [14:0] pc;
  int fail_count = 0;
  int checked = 0;
  int cyc = 0;
  // Model: register image by port offset, and the program counter
  logic [7:0] m_r [16];
  logic [14:0] m_pc;

  cmro_core DUT
  (
    .clk_sys(clk_sys),
    .srst(srst),
    .instr_valid(instr_valid),
    .instr_word(instr_word),
    .instr_ready(instr_ready),
    .instr_unhandled(instr_unhandled),
    .stack_top(stack_top),
    .stack_pop(stack_pop),
    .mem_wr(mem_wr),
    .mem_addr(mem_addr),
    .mem_data(mem_data),
    .pc(pc),
    .timer_option(timer_option),
    .global_interrupt_enable(global_interrupt_enable),
    .soft_reset_pulse(soft_reset_pulse),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata)
  );

  // Clock, and a ceiling on run time in case the design hangs
  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      fail_count++;
      results();
    end
  end

  task automatic results();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results

  task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : cmp

  // Reset image; only the reset-instruction flag differs by cause
  task automatic mrst(input logic [7:0] pw);
    foreach (m_r[k])
      m_r[k] = 8'h00;
    m_r[1] = 8'hFF;
    m_r[7] = pw;
    m_pc = 15'h0000;
  endtask : mrst

  function automatic logic [15:0] pg(input logic n);
    return n ? {m_r[5], m_r[4]} : {m_r[3], m_r[2]};
  endfunction : pg

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    if (a <= 4'h8)
      m_r[a] = d;
  endtask : wr

  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    m_r[9] = m_pc[7:0];
    m_r[10] = {1'b0, m_pc[14:8]};
    cmp("reg", {4'h0, a, m_r[a]}, {4'h0, a, reg_rdata});
  endtask : rd

  // One instruction, then every result against the model
  task automatic ex(input logic [13:0] w);
    logic [15:0] p, e_a, q;
    logic e_w;
    logic e_u;
    e_w = 1'b0;
    e_u = 1'b0;
    e_a = 16'h0000;
    @(posedge clk_sys);
    instr_valid <= 1'b1;
    instr_word <= w;
    stack_top <= 15'($urandom);
    @(posedge clk_sys);
    instr_valid <= 1'b0;
    #1;
    m_pc = m_pc + 15'h0001;
    p = pg(w[2]);
    if (w[13:7] == 7'h01)
    begin
      e_w = 1'b1;
      e_a = (w[6:1] == 6'h00) ? pg(w[0]) : {9'h000, w[6:0]};
    end
    else if (w[13:3] == 11'h003)
    begin
      e_w = 1'b1;
      e_a = w[1:0] == 2'b00 ? p + 16'h0001 : w[1:0] == 2'b01 ? p - 16'h0001 : p;
      q = w[0] ? p - 16'h0001 : p + 16'h0001;
      m_r[w[2] ? 4 : 2] = q[7:0];
      m_r[w[2] ? 5 : 3] = q[15:8];
    end
    else if (w[13:7] == 7'h7F)
    begin
      e_w = 1'b1;
      e_a = pg(w[6]) + {{10{w[5]}}, w[5:0]};
    end
    else if (w == 14'h0062)
      m_r[1] = m_r[0];
    else if (w[13:1] == 13'h0004)
    begin
      m_pc = stack_top;
      m_r[6][7] = m_r[6][7] | w[0];
    end
    else if (w == 14'h0001)
      mrst(8'h00);
    else if (w != 14'h0000)
    begin
      // Outside the subset: nothing moves, not even the program counter
      e_u = 1'b1;
      m_pc = m_pc - 15'h0001;
    end
    cmp("wr", e_w, mem_wr);
    if (e_w)
      cmp("addr", e_a, mem_addr);
    if (e_w)
      cmp("data", m_r[0], mem_data);
    cmp("pc", m_pc, pc);
    cmp("pop", w[13:1] == 13'h0004, stack_pop);
    cmp("rdy", w[13:1] != 13'h0004, instr_ready);
    cmp("opt", m_r[1], timer_option);
    cmp("glb_int_en", m_r[6][7], global_interrupt_enable);
    cmp("srp", w == 14'h0001, soft_reset_pulse);
    cmp("unh", e_u, instr_unhandled);
  endtask : ex

  // Main sequence: random setup, one instruction of each kind in turn, full read-back
  initial
  begin
    logic [13:0] w;
    void'($urandom(32'hd22980cf));
    mrst(8'h04);
    repeat (16) @(posedge clk_sys);
    srst <= 1'b0;
    for (int a = 0; a < 16; a++)
      rd(4'(a));
    for (int i = 0; i < 64; i++)
    begin
      wr(4'h0, 8'($urandom));
      for (int b = 2; b < 6; b++)
        wr(4'(b), i % 3 == 0 ? 8'hFF : i % 3 == 1 ? 8'h00 : 8'($urandom));
      wr(4'h6, 8'($urandom) & 8'h7F);
      wr(4'h8, 8'($urandom));
      wr(4'(9 + i % 7), 8'($urandom));
      case (i % 8)
        0: w = {7'h01, i < 16 ? 7'(i / 8) : 7'($urandom)};
        1, 2: w = {11'h003, 1'(i / 32), 2'(i / 8)};
        3: w = {7'h7F, 1'(i / 32), 6'($urandom)};
        4: w = 14'h0062;
        5: w = i < 32 ? 14'h0000 : {7'h60, 7'($urandom)};
        6: w = {13'h0004, 1'(i / 8)};
        default: w = 14'h0001;
      endcase
      ex(w);
      for (int a = 0; a < 16; a++)
        rd(4'(a));
    end
    results();
  end
endmodule : testbench

`default_nettype wire
